// ===== core/bus_master_map.vh
// bus master constants: sizes, acknowledge codes, timing counts
// assumes inclusion by the bus master design file and by the testbench
`ifndef BUS_MASTER_MAP_VH
`define BUS_MASTER_MAP_VH

// transfer size codes on the two size pins
`define SIZE_LONG      2'h0
`define SIZE_BYTE      2'h1
`define SIZE_WORD      2'h2
`define SIZE_THREE     2'h3

// acknowledge patterns {upper, lower}, active low
`define ACK_WAIT       2'h3
`define ACK_PORT8      2'h2
`define ACK_PORT16     2'h1
`define ACK_RESERVED   2'h0

// reset drive length in clock cycles, counter width
`define RESET_HOLD_CYC 10'h200
`define RESET_CNT_W    10

// state codes
`define ST_IDLE        3'h0
`define ST_ADDR        3'h1
`define ST_WAIT        3'h2
`define ST_NEXT        3'h3
`define ST_HALTED      3'h4

// autovector base and fixed fields
`define AUTOVEC_BASE   8'h18
`define ZERO_BYTE      8'h00
`define ZERO_WORD      16'h0000
`define ZERO_LONG      32'h00000000
`define ADDR_ONE       32'h00000001
`define LEVEL_NMI      3'h7
`define LEVEL_NONE     3'h0

`endif

// ===== core/bus_master.v
// bus master: asynchronous cycles with dynamic 8/16-bit port sizing
// assumes a cpu side that issues one request and waits for done or fault
//
// Contract
// - both acknowledges high insert wait states
// - upper high lower low completes 8-bit
// - upper low lower high completes 16-bit
// - both low treated as 16-bit port
// - read latches data then ends cycle
// - address strobe asserts half clock in
// - lock indicator held across whole rmw
// - driven reset held at least 512 cycles
// - software reset spares processor state
// - external halt suspends bus, retry with fault
// - halt driven low on double fault
// - bus fault ends cycle as faulted
// - bus clock at half the system clock driven out to bus
// - word read captured from lines 15-0
// - word write driven on lines 15-0
// - byte reads from 15-8, msb first
// - per byte decrement size, increment address
// - long write first cycle drives upper bytes
// - size/a0 sequence 00/0,11/1,10/0,01/1
// - autovector makes vector internally
// - level 7 non-maskable, others masked
`timescale 1ns/100ps
`include "bus_master_map.vh"

module bus_master (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // cpu request side
  input  wire        reqStart,
  input  wire        reqWrite,
  input  wire        reqLocked,
  input  wire        reqLockEnd,
  input  wire        reqIack,
  input  wire [1:0]  reqSize,
  input  wire [31:0] reqAddr,
  input  wire [31:0] reqData,
  input  wire        doubleFault,
  input  wire        softReset,
  input  wire [2:0]  intMask,
  output reg         reqDone_q,
  output reg         reqFault_q,
  output reg         reqRetry_q,
  output reg  [31:0] rdData_q,
  output reg  [7:0]  vector_q,
  output reg         busy_q,
  output reg  [2:0]  intLevel_q,
  output reg         modReset_q,
  // bus pins
  output reg  [31:0] addr_q,
  output reg  [15:0] dataOut_q,
  output reg         dataOe_q,
  input  wire [15:0] dataIn,
  output reg         xfer_size_hi,
  output reg         xfer_size_lo,
  output reg         rdWrite_n_q,
  output reg         addr_strobe_n,
  output reg         locked_rmw_n,
  input  wire        size_ack_upper,
  input  wire        size_ack_lower,
  input  wire        bus_fault_n,
  input  wire        auto_vector_req_n,
  output reg         bus_clock_out,
  // open-drain lines as three signals each
  input  wire        resetIn_n,
  output reg         resetOut_q,
  output reg         resetOe_q,
  input  wire        haltIn_n,
  output reg         haltOut_q,
  output reg         haltOe_q,
  // interrupt request levels, active low, 7 is non-maskable
  input  wire        nmi_level_req_n,
  input  wire [6:1]  irqLevel_n
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg  [4:0] syncA_q;
  reg  [4:0] syncB_q;
  wire [4:0] rawIn = {size_ack_upper, size_ack_lower, bus_fault_n, haltIn_n,
                      auto_vector_req_n};

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= 5'h1F;
      syncB_q <= 5'h1F;
    end else begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
    end
  end

  wire [1:0] ackS    = syncB_q[4:3];
  wire       faultS  = ~syncB_q[2];
  wire       haltS   = ~syncB_q[1];
  wire       avecS   = ~syncB_q[0];

  // ----------------------------------------------------------------
  // bus clock output, one bus phase per system clock
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_clock_out <= 1'b0;
    end else begin
      bus_clock_out <= ~bus_clock_out;
    end
  end

  // ----------------------------------------------------------------
  // bus cycle state machine
  // ----------------------------------------------------------------
  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [1:0]  remain_q;
  reg [31:0] shift_q;
  reg        lockHeld_q;

  wire ackValid = (ackS != `ACK_WAIT);
  wire port8    = (ackS == `ACK_PORT8);
  // reserved pattern falls through as a 16-bit port
  wire port16   = ackValid && !port8;

  // the size counter walks long->three->word->byte on 8-bit ports
  wire [1:0] nextRemain = remain_q - 2'h1;
  wire       lastByte   = (remain_q == `SIZE_BYTE);
  wire       lastWord16 = port16 && (remain_q == `SIZE_WORD || remain_q == `SIZE_BYTE);
  // autovector alone ends an interrupt acknowledge cycle
  wire       avecEnd    = reqIack && avecS;
  wire       opComplete = (port8 && lastByte) || lastWord16;

  always @* begin
    state_d = state_q;
    case (state_q)
      `ST_IDLE: begin
        if (doubleFault) begin
          state_d = `ST_HALTED;
        end else if (reqStart && !haltS) begin
          state_d = `ST_ADDR;
        end
      end
      `ST_ADDR: begin
        state_d = `ST_WAIT;
      end
      `ST_WAIT: begin
        // only a fault or an autovector in an acknowledge cycle ends the cycle while both acknowledges are negated
        if (faultS) begin
          state_d = `ST_IDLE;
        end else if (ackValid || avecEnd) begin
          state_d = (opComplete || avecEnd) ? `ST_IDLE : `ST_NEXT;
        end
      end
      `ST_NEXT: begin
        // held while halt is asserted, and until the synchronised
        // acknowledge of the last cycle has cleared, so a stale one
        // cannot end the next cycle early
        if (!haltS && !ackValid && !faultS) begin
          state_d = `ST_ADDR;
        end
      end
      `ST_HALTED: begin
        state_d = `ST_HALTED;
      end
      default: begin
        state_d = `ST_IDLE;
      end
    endcase
  end

  // long operand split over the pending word: upper 16 bits go first
  wire [15:0] upperWord = shift_q[31:16];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q       <= `ST_IDLE;
      remain_q      <= `SIZE_LONG;
      shift_q       <= `ZERO_LONG;
      addr_q        <= `ZERO_LONG;
      dataOut_q     <= `ZERO_WORD;
      dataOe_q      <= 1'b0;
      rdWrite_n_q   <= 1'b1;
      addr_strobe_n <= 1'b1;
      xfer_size_hi  <= 1'b0;
      xfer_size_lo  <= 1'b0;
      reqDone_q     <= 1'b0;
      reqFault_q    <= 1'b0;
      reqRetry_q    <= 1'b0;
      rdData_q      <= `ZERO_LONG;
      vector_q      <= `ZERO_BYTE;
      busy_q        <= 1'b0;
      lockHeld_q    <= 1'b0;
      locked_rmw_n  <= 1'b1;
      haltOut_q     <= 1'b0;
      haltOe_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      reqDone_q  <= 1'b0;
      reqFault_q <= 1'b0;
      reqRetry_q <= 1'b0;
      case (state_q)
        `ST_IDLE: begin
          if (reqStart && !haltS && !doubleFault) begin
            remain_q     <= reqSize;
            shift_q      <= reqData;
            addr_q       <= reqAddr;
            rdWrite_n_q  <= ~reqWrite;
            xfer_size_hi <= reqSize[1];
            xfer_size_lo <= reqSize[0];
            busy_q       <= 1'b1;
            // lock runs from the first cycle until the cpu ends the sequence
            if (reqLocked) begin
              lockHeld_q   <= 1'b1;
              locked_rmw_n <= 1'b0;
            end
            // upper two bytes of a long, or the word itself, on 15-0
            dataOut_q    <= (reqSize == `SIZE_LONG) ? reqData[31:16] : reqData[15:0];
            dataOe_q     <= reqWrite;
          end
          if (reqLockEnd && lockHeld_q) begin
            lockHeld_q   <= 1'b0;
            locked_rmw_n <= 1'b1;
          end
        end
        `ST_ADDR: begin
          // strobe one clock after address setup, half a bus clock period
          addr_strobe_n <= 1'b0;
        end
        `ST_WAIT: begin
          if (faultS) begin
            addr_strobe_n <= 1'b1;
            dataOe_q      <= 1'b0;
            busy_q        <= 1'b0;
            reqFault_q    <= !haltS;
            reqRetry_q    <= haltS;
          end else if (ackValid || avecEnd) begin
            addr_strobe_n <= 1'b1;
            if (port8) begin
              // bytes arrive msb first on 15-8; 7-0 is ignored
              rdData_q <= {rdData_q[23:0], dataIn[15:8]};
              if (!lastByte) begin
                remain_q     <= nextRemain;
                addr_q       <= addr_q + `ADDR_ONE;
                xfer_size_hi <= nextRemain[1];
                xfer_size_lo <= nextRemain[0];
                shift_q      <= {shift_q[23:0], `ZERO_BYTE};
                dataOut_q    <= {shift_q[23:16], shift_q[15:8]};
              end
            end else begin
              if (remain_q == `SIZE_LONG || remain_q == `SIZE_THREE) begin
                rdData_q     <= {rdData_q[15:0], dataIn};
                remain_q     <= `SIZE_WORD;
                addr_q       <= addr_q + `ADDR_ONE + `ADDR_ONE;
                xfer_size_hi <= 1'b1;
                xfer_size_lo <= 1'b0;
                shift_q      <= {shift_q[15:0], `ZERO_WORD};
                dataOut_q    <= shift_q[15:0];
              end else begin
                rdData_q <= {rdData_q[15:0], dataIn};
              end
            end
            if (opComplete || avecEnd) begin
              dataOe_q  <= 1'b0;
              busy_q    <= 1'b0;
              reqDone_q <= 1'b1;
              if (reqIack) begin
                // autovector: vector from the level instead of the data bus
                vector_q <= avecS ? (`AUTOVEC_BASE + {5'h00, intLevel_q})
                                  : dataIn[7:0];
              end
            end
          end
        end
        `ST_HALTED: begin
          haltOut_q <= 1'b0;
          haltOe_q  <= 1'b1;
          busy_q    <= 1'b0;
        end
        default: begin
          addr_strobe_n <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // reset line driver and module reset
  // ----------------------------------------------------------------
  reg [`RESET_CNT_W-1:0] rstCnt_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstCnt_q   <= {`RESET_CNT_W{1'b0}};
      resetOut_q <= 1'b0;
      resetOe_q  <= 1'b0;
      modReset_q <= 1'b0;
    end else begin
      resetOut_q <= 1'b0;
      if (softReset && rstCnt_q == {`RESET_CNT_W{1'b0}}) begin
        rstCnt_q  <= `RESET_HOLD_CYC;
        resetOe_q <= 1'b1;
      end else if (rstCnt_q != {`RESET_CNT_W{1'b0}}) begin
        rstCnt_q <= rstCnt_q - {{(`RESET_CNT_W-1){1'b0}}, 1'b1};
      end else begin
        // released only after the full count, never one cycle short
        resetOe_q <= 1'b0;
      end
      // only on-chip modules: cpu state and this block stay intact
      modReset_q <= (rstCnt_q != {`RESET_CNT_W{1'b0}}) || !resetIn_n;
    end
  end

  // ----------------------------------------------------------------
  // interrupt level encoder
  // ----------------------------------------------------------------
  reg [2:0] level_d;
  integer   i;

  always @* begin
    level_d = `LEVEL_NONE;
    for (i = 1; i < 7; i = i + 1) begin
      if (!irqLevel_n[i] && (i[2:0] > intMask)) begin
        level_d = i[2:0];
      end
    end
    // level 7 ignores the mask
    if (!nmi_level_req_n) begin
      level_d = `LEVEL_NMI;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intLevel_q <= `LEVEL_NONE;
    end else begin
      intLevel_q <= level_d;
    end
  end

endmodule

// ===== bench/bus_master_assertions.sv
// checker: timing relations seen at the bus master pins
// assumes a bind onto bus_master and a single clock domain
`timescale 1ns/100ps
module bus_master_assertions (
  input wire clk,
  input wire reset_n,
  input wire busy_q,
  input wire addr_strobe_n,
  input wire size_ack_upper,
  input wire size_ack_lower,
  input wire bus_fault_n,
  input wire auto_vector_req_n,
  input wire haltIn_n,
  input wire locked_rmw_n,
  input wire resetOe_q,
  input wire haltOe_q,
  input wire doubleFault,
  input wire reqFault_q,
  input wire reqRetry_q,
  input wire bus_clock_out
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  reg  [10:0] rstCnt_q;
  wire        ackIdle = size_ack_upper & size_ack_lower & bus_fault_n & auto_vector_req_n;
  sequence ackLow;
    !addr_strobe_n && !(size_ack_upper && size_ack_lower);
  endsequence
  sequence faultHalt;
    !addr_strobe_n && !bus_fault_n && !haltIn_n;
  endsequence
  // drive length, cleared whenever the line is let go
  always @(posedge clk or negedge reset_n)
    if (!reset_n) rstCnt_q <= 11'h000;
    else if (resetOe_q) rstCnt_q <= rstCnt_q + 11'h001;
    else rstCnt_q <= 11'h000;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_clock_toggles: assert property ($past(reset_n) |-> bus_clock_out != $past(bus_clock_out))
    else $error("bus clock stuck");
  a_strobe_half: assert property ($rose(busy_q) |=> $fell(addr_strobe_n))
    else $error("strobe late");
  // synchronizer delay: four idle cycles in a row forbid an end, as would three
  a_wait_extend: assert property ((!addr_strobe_n && ackIdle) [*4] |=> !addr_strobe_n)
    else $error("cycle ended without ack");
  a_ack_ends: assert property (ackLow [*2] |-> ##[1:4] addr_strobe_n)
    else $error("ack did not end cycle");
  a_lock_held: assert property (!locked_rmw_n && busy_q |=> !locked_rmw_n)
    else $error("lock dropped in operation");
  a_reset_length: assert property ($fell(resetOe_q) |-> rstCnt_q >= 11'h200)
    else $error("reset drive too short");
  a_double_halt: assert property (doubleFault && !busy_q |-> ##[1:3] haltOe_q)
    else $error("halt not driven");
  a_fault_end: assert property ((!addr_strobe_n && !bus_fault_n && haltIn_n) [*3] |->
    ##[0:3] reqFault_q)
    else $error("fault not reported");
  a_retry_req: assert property (faultHalt [*3] |-> ##[0:3] reqRetry_q)
    else $error("retry not reported");
  a_halt_refuse: assert property ((!haltIn_n && !busy_q) [*3] |=> !busy_q)
    else $error("started while halted");
endmodule
bind bus_master bus_master_assertions bus_master_assertions_i (
  .clk, .reset_n, .busy_q, .addr_strobe_n, .size_ack_upper, .size_ack_lower, .bus_fault_n,
  .auto_vector_req_n, .haltIn_n, .locked_rmw_n, .resetOe_q, .haltOe_q, .doubleFault,
  .reqFault_q, .reqRetry_q, .bus_clock_out);

// ===== bench/bus_slave_model.sv
// slave model: byte memory with 8-bit, 16-bit, reserved, fault and autovector answers
// assumes strobe, address and data from the bus master; mode chosen by the bench
`timescale 1ns/100ps
module bus_slave_model (
  input  wire        clk,
  input  wire [31:0] addr_q,
  input  wire [15:0] dataOut_q,
  input  wire        rdWrite_n_q,
  input  wire        addr_strobe_n,
  input  wire [2:0]  mode,
  input  wire [1:0]  waitCyc,
  output reg  [1:0]  ack,
  output reg         fault_n,
  output reg         haltDrv,
  output reg         auto_vector_req_n_n,
  output reg  [15:0] dataIn
);
  // ---------------------------------------------------------------
  // answer logic
  // ---------------------------------------------------------------
  reg  [7:0] mem [0:255];
  reg  [1:0] cnt = 2'h0;
  wire [7:0] a = addr_q[7:0];
  initial ack = 2'h3;
  initial fault_n = 1'h1;
  initial haltDrv = 1'h0;
  initial auto_vector_req_n_n = 1'h1;
  initial dataIn = 16'h0000;
  always @(posedge clk) begin
    dataIn <= ~dataIn; // released lines never hold old data
    if (addr_strobe_n) begin
      ack <= 2'h3;
      fault_n <= 1'h1;
      haltDrv <= 1'h0;
      auto_vector_req_n_n <= 1'h1;
      cnt <= 2'h0;
    end else if (cnt != waitCyc) begin
      cnt <= cnt + 2'h1;
    end else begin
      case (mode)
        3'h3, 3'h4: begin
          fault_n <= 1'h0;
          haltDrv <= mode[2];
        end
        3'h5: auto_vector_req_n_n <= 1'h0;
        default: begin
          ack <= mode == 3'h0 ? 2'h2 : mode == 3'h1 ? 2'h1 : 2'h0;
          if (!rdWrite_n_q) begin
            mem[a] <= dataOut_q[15:8];
            if (mode != 3'h0) mem[a | 8'h01] <= dataOut_q[7:0];
          end else if (mode == 3'h0) dataIn <= {mem[a], ~dataIn[7:0]};
          else dataIn <= {mem[a & 8'hFE], mem[a | 8'h01]};
        end
      endcase
    end
  end
endmodule

// ===== bench/async_bus_master_dynamic_sizing_tb.sv
// testbench: bus master against the slave model and a byte mirror
// assumes core/ design files and the checker bound in its own file
`timescale 1ns/100ps
`include "bus_master_map.vh"
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module async_bus_master_dynamic_sizing_tb;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  reg         clk = '0, reset_n = '0, reqStart = '0, reqWrite = '0, reqLocked = '0;
  reg         reqLockEnd = '0, reqIack = '0, doubleFault = '0, softReset = '0, hold = '0;
  reg         nmi_level_req_n = '1;
  reg  [1:0]  reqSize = '0;
  reg  [2:0]  intMask = '0, slvMode = '0;
  reg  [6:1]  irqLevel_n = '1;
  reg  [31:0] reqAddr = '0, reqData = '0, rng = 32'h61D7566C, a, d;
  reg  [7:0]  expMem [0:255];
  reg  [2:0]  sizeLog [$];
  reg  [31:0] addrLog [$];
  wire        reqDone_q, reqFault_q, reqRetry_q, busy_q, modReset_q, xfer_size_hi;
  wire        xfer_size_lo, rdWrite_n_q, addr_strobe_n, locked_rmw_n, resetOe_q, haltOe_q;
  wire        fault_n, haltDrv, auto_vector_req_n_n, dataOe_q, haltOut_q;
  wire [1:0]  ack;
  wire [2:0]  intLevel_q;
  wire [7:0]  vector_q;
  wire [15:0] dataOut_q, dataIn;
  wire [31:0] rdData_q, addr_q;
  wire        resetIn_n = ~resetOe_q; // pulled up when let go
  wire        haltIn_n = ~(haltOe_q | haltDrv | hold);
  int         n_fail = 0, tests_run = 0, cyc = 0, i, p, n;
  bus_master bus_master_i (
    .clk, .reset_n, .reqStart, .reqWrite, .reqLocked, .reqLockEnd, .reqIack, .reqSize,
    .reqAddr, .reqData, .doubleFault, .softReset, .intMask, .reqDone_q, .reqFault_q,
    .reqRetry_q, .rdData_q, .vector_q, .busy_q, .intLevel_q, .modReset_q, .addr_q,
    .dataOut_q, .dataOe_q, .dataIn, .xfer_size_hi, .xfer_size_lo, .rdWrite_n_q,
    .addr_strobe_n, .locked_rmw_n, .size_ack_upper(ack[1]), .size_ack_lower(ack[0]),
    .bus_fault_n(fault_n), .auto_vector_req_n(auto_vector_req_n_n), .bus_clock_out(), .resetIn_n,
    .resetOut_q(), .resetOe_q, .haltIn_n, .haltOut_q, .haltOe_q, .nmi_level_req_n,
    .irqLevel_n);
  bus_slave_model bus_slave_model_i (
    .clk, .addr_q, .dataOut_q, .rdWrite_n_q, .addr_strobe_n, .mode(slvMode),
    .waitCyc(rng[1:0]), .ack, .fault_n, .haltDrv, .auto_vector_req_n_n, .dataIn);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task final_report();
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic op(input w, input [1:0] sz, input [31:0] ad, input [31:0] dt);
    int k;
    @(posedge clk);
    reqStart <= 1'h1;
    reqWrite <= w;
    reqSize <= sz;
    reqAddr <= ad;
    reqData <= dt;
    @(posedge clk);
    reqStart <= 1'h0;
    for (k = 0; k < 200 && {reqDone_q, reqFault_q, reqRetry_q} === 3'h0; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK("op end", 1, k < 200)
    `CHK("data enable", 1'h0, dataOe_q)
  endtask
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end
  always @(negedge addr_strobe_n) begin
    sizeLog.push_back({xfer_size_hi, xfer_size_lo, addr_q[0]});
    addrLog.push_back(addr_q);
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    for (p = 0; p < 3; p++) begin
      slvMode <= p[2:0];
      a = rnd() & 32'h000000FC;
      d = rnd();
      sizeLog.delete();
      addrLog.delete();
      op(1'h1, `SIZE_LONG, a, d);
      for (i = 0; i < 4; i++) expMem[a + i] = d[31 - 8 * i -: 8];
      op(1'h0, `SIZE_LONG, a, `ZERO_LONG);
      `CHK("long", {expMem[a], expMem[a + 1], expMem[a + 2], expMem[a + 3]}, rdData_q)
      `CHK("cycles", p == 0 ? 8 : 4, sizeLog.size())
      for (i = 0; i < 8 && p == 0; i++) begin
        `CHK("size pins", {2'(4 - i % 4), 1'(i % 2)}, sizeLog[i])
        `CHK("address", a + i % 4, addrLog[i])
      end
    end
    slvMode <= 3'h1;
    d = rnd();
    reqLocked <= 1'h1;
    op(1'h0, `SIZE_WORD, a, `ZERO_LONG);
    op(1'h1, `SIZE_WORD, a, d);
    `CHK("lock", 1'h0, locked_rmw_n)
    reqLocked <= 1'h0;
    op(1'h0, `SIZE_WORD, a, `ZERO_LONG);
    `CHK("word", d[15:0], rdData_q[15:0])
    reqLockEnd <= 1'h1;
    @(posedge clk);
    reqLockEnd <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("unlock", 1'h1, locked_rmw_n)
    for (p = 3; p < 5; p++) begin
      slvMode <= p[2:0];
      op(1'h0, `SIZE_WORD, a, `ZERO_LONG);
      `CHK("fault", p == 3 ? 2'h2 : 2'h1, {reqFault_q, reqRetry_q})
    end
    hold <= 1'h1;
    repeat (4) @(posedge clk);
    reqStart <= 1'h1;
    repeat (6) @(posedge clk);
    reqStart <= 1'h0;
    hold <= 1'h0;
    #1;
    `CHK("halted", 2'h1, {busy_q, addr_strobe_n})
    for (p = 1; p < 8; p++) begin
      @(posedge clk);
      intMask <= rng[2:0];
      irqLevel_n <= ~(6'h01 << (p - 1));
      nmi_level_req_n <= p != 7;
      repeat (6) @(posedge clk);
      #1;
      `CHK("level", 3'(p == 7 || p > rng[2:0] ? p : 0), intLevel_q)
      void'(rnd());
    end
    @(posedge clk);
    nmi_level_req_n <= 1'h1;
    irqLevel_n <= 6'h2F;
    intMask <= 3'h0;
    slvMode <= 3'h5;
    reqIack <= 1'h1;
    repeat (6) @(posedge clk);
    op(1'h0, `SIZE_BYTE, `ZERO_LONG, `ZERO_LONG);
    `CHK("vector", `AUTOVEC_BASE + 8'h05, vector_q)
    reqIack <= 1'h0;
    softReset <= 1'h1;
    @(posedge clk);
    softReset <= 1'h0;
    for (n = 0; n < 9 && resetOe_q !== 1'h1; n++) @(posedge clk);
    #1;
    for (n = 0; n < 2000 && resetOe_q === 1'h1; n++) begin
      if (n == 100) `CHK("module reset", 1'h1, modReset_q)
      @(posedge clk);
      #1;
    end
    `CHK("reset drive", 1, n >= 512)
    @(posedge clk);
    doubleFault <= 1'h1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("double fault", 1'h1, haltOe_q)
    `CHK("halt level", 1'h0, haltOut_q)
    final_report();
  end
endmodule
